// ---- iir_defines.vh ----
// constants for the indexed interrupt redirector
// assumes byte addresses on a 32-bit memory bus
`ifndef IIR_DEFINES_VH
`define IIR_DEFINES_VH
`define IIR_ADDR_INDEX 32'hfec00000
`define IIR_ADDR_DATA 32'hfec00010
`define IIR_IDX_IDENTITY 8'h00
`define IIR_IDX_VERSION 8'h01
`define IIR_IDX_ARB 8'h02
`define IIR_IDX_ENT_FIRST 8'h10
`define IIR_IDX_ENT_LAST 8'h3f
`define IIR_ID_HI 27
`define IIR_ID_LO 24
`define IIR_BIT_MASK 16
`define IIR_BIT_TRIG 15
`define IIR_BIT_IRR 14
`define IIR_BIT_POL 13
`define IIR_BIT_PEND 12
`define IIR_BIT_DMODE 11
`define IIR_DLV_HI 10
`define IIR_DLV_LO 8
`define IIR_VEC_HI 7
`define IIR_VEC_LO 0
`define IIR_PHYS_HI 3
`define IIR_INDEX_RESET 8'h00
`define IIR_ENT_LOW_RESET 17'h10000
`define IIR_ENT_LOW_WMASK 17'h1afff
`define IIR_ID_RESET 4'h0
`define IIR_BE_ALL 4'hf
`endif

// ---- iir_redirector.v ----
// indexed interrupt redirection unit: index/data ports, 24 entries, message out
// assumes inputs synchronous to clk; destination acknowledges with msg_accept
// assumes the destination may hold off msg_accept for any number of cycles
`include "iir_defines.vh"
module iir_redirector #(
  parameter N_IN = 24,
  parameter [31:0] VERSION_VALUE = 32'h00010002 // arbitrary value
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // memory-mapped access
  input wire [31:0] mem_addr,
  input wire mem_wr,
  input wire mem_rd,
  input wire [3:0] mem_be,
  input wire [31:0] mem_wdata,
  output reg [31:0] mem_rdata,
  output reg mem_rvalid,
  // interrupt inputs
  input wire [N_IN-1:0] irq_in,
  // interrupt message to processors
  output reg msg_valid,
  output reg [7:0] msg_dest,
  output reg msg_dest_logical,
  output reg [2:0] msg_delivery,
  output reg msg_level,
  output reg [7:0] msg_vector,
  output reg [4:0] msg_input,
  input wire msg_accept,
  // end of interrupt from processors
  input wire eoi_valid,
  input wire [7:0] eoi_vector
);

  reg [7:0] index;
  reg [3:0] unit_id;
  reg [3:0] arb_id;
  reg [16:0] ent_low [0:N_IN-1];
  reg [7:0] ent_dest [0:N_IN-1];
  reg [N_IN-1:0] request_received_flag;
  reg [N_IN-1:0] pend;
  reg [N_IN-1:0] prev_active;
  reg [4:0] next_sel;
  reg next_found;
  integer k_sel;
  integer k_ent;
  integer k_irr;
  integer k_pend;
  reg [31:0] next_rdata;
  reg next_rvalid;

  // true when the index falls in the entry range
  function is_entry;
    input [7:0] idx;
    begin
      is_entry = (idx >= `IIR_IDX_ENT_FIRST) && (idx <= `IIR_IDX_ENT_LAST);
    end
  endfunction

  // entry number for an entry index
  function [4:0] entry_of;
    input [7:0] idx;
    reg [7:0] off;
    begin
      off = idx - `IIR_IDX_ENT_FIRST;
      entry_of = off[5:1];
    end
  endfunction

  // low word of an entry as software sees it; status bits come from hardware
  function [31:0] low_word;
    input [16:0] cfg;
    input irr_bit;
    input pend_bit;
    begin
      low_word = 32'h00000000;
      low_word[`IIR_BIT_MASK] = cfg[`IIR_BIT_MASK];
      low_word[`IIR_BIT_TRIG] = cfg[`IIR_BIT_TRIG];
      low_word[`IIR_BIT_IRR] = irr_bit & cfg[`IIR_BIT_TRIG];
      low_word[`IIR_BIT_POL] = cfg[`IIR_BIT_POL];
      low_word[`IIR_BIT_PEND] = pend_bit;
      low_word[`IIR_BIT_DMODE] = cfg[`IIR_BIT_DMODE];
      low_word[`IIR_DLV_HI:`IIR_VEC_LO] = cfg[`IIR_DLV_HI:`IIR_VEC_LO];
    end
  endfunction

  // physical mode keeps only the four id bits of the destination
  function [7:0] dest_of;
    input logical;
    input [7:0] dest;
    begin
      if (logical) begin
        dest_of = dest;
      end else begin
        dest_of = {4'h0, dest[`IIR_PHYS_HI:0]};
      end
    end
  endfunction

  // register port decode
  wire sel_index = (mem_addr == `IIR_ADDR_INDEX);
  wire sel_data = (mem_addr == `IIR_ADDR_DATA);
  wire data_wr = mem_wr && sel_data && (mem_be == `IIR_BE_ALL);
  wire index_wr = mem_wr && sel_index && mem_be[0];
  wire [4:0] cur_ent = entry_of(index);
  wire cur_is_ent = is_entry(index);
  // configuration of the input about to be sent
  wire [16:0] sel_cfg = ent_low[next_sel];
  wire [7:0] sel_dest = ent_dest[next_sel];
  wire msg_taken = msg_valid && msg_accept;

  // per-input configuration and detection
  wire [N_IN-1:0] cfg_mask;
  wire [N_IN-1:0] cfg_level;
  wire [N_IN-1:0] active;
  wire [N_IN-1:0] event_in;
  wire [N_IN-1:0] eoi_hit;
  genvar g;
  generate
    for (g = 0; g < N_IN; g = g + 1) begin : g_in
      assign cfg_mask[g] = ent_low[g][`IIR_BIT_MASK];
      assign cfg_level[g] = ent_low[g][`IIR_BIT_TRIG];
      assign active[g] = irq_in[g] ^ ent_low[g][`IIR_BIT_POL];
      assign event_in[g] = !cfg_mask[g] && (cfg_level[g] ?
        (active[g] && !request_received_flag[g] && !pend[g]) :
        (active[g] && !prev_active[g]));
      assign eoi_hit[g] = eoi_valid && (eoi_vector == ent_low[g][7:0]);
    end
  endgenerate

  // lowest pending input wins the message slot
  always @* begin
    next_sel = 5'h00;
    next_found = 1'b0;
    for (k_sel = N_IN - 1; k_sel >= 0; k_sel = k_sel - 1) begin
      if (pend[k_sel]) begin
        next_sel = k_sel[4:0];
        next_found = 1'b1;
      end
    end
  end

  // index register and identity registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      index <= `IIR_INDEX_RESET;
      unit_id <= `IIR_ID_RESET;
      arb_id <= `IIR_ID_RESET;
    end else begin
      if (index_wr) begin
        index <= mem_wdata[7:0];
      end
      if (data_wr && index == `IIR_IDX_IDENTITY) begin
        unit_id <= mem_wdata[`IIR_ID_HI:`IIR_ID_LO];
        arb_id <= mem_wdata[`IIR_ID_HI:`IIR_ID_LO];
      end
    end
  end

  // redirection entry storage
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (k_ent = 0; k_ent < N_IN; k_ent = k_ent + 1) begin
        ent_low[k_ent] <= `IIR_ENT_LOW_RESET;
        ent_dest[k_ent] <= 8'h00;
      end
    end else if (data_wr && cur_is_ent && cur_ent < N_IN) begin
      if (index[0]) begin
        ent_dest[cur_ent] <= mem_wdata[31:24];
      end else begin
        ent_low[cur_ent] <= mem_wdata[16:0] & `IIR_ENT_LOW_WMASK;
      end
    end
  end

  // edge history for the edge-triggered inputs
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_active <= {N_IN{1'b0}};
    end else begin
      prev_active <= active;
    end
  end

  // request-received: detection beats a same-cycle end-of-interrupt
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      request_received_flag <= {N_IN{1'b0}};
    end else begin
      for (k_irr = 0; k_irr < N_IN; k_irr = k_irr + 1) begin
        if (event_in[k_irr] && cfg_level[k_irr]) begin
          request_received_flag[k_irr] <= 1'b1;
        end else if (eoi_hit[k_irr] || !cfg_level[k_irr]) begin
          request_received_flag[k_irr] <= 1'b0;
        end
      end
    end
  end

  // pending delivery: a new event beats a same-cycle accept
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend <= {N_IN{1'b0}};
    end else begin
      for (k_pend = 0; k_pend < N_IN; k_pend = k_pend + 1) begin
        if (event_in[k_pend]) begin
          pend[k_pend] <= 1'b1;
        end else if (msg_taken && msg_input == k_pend[4:0]) begin
          pend[k_pend] <= 1'b0;
        end
      end
    end
  end

  // message out: held until accepted
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      msg_valid <= 1'b0;
      msg_dest <= 8'h00;
      msg_dest_logical <= 1'b0;
      msg_delivery <= 3'h0;
      msg_level <= 1'b0;
      msg_vector <= 8'h00;
      msg_input <= 5'h00;
    end else if (msg_valid) begin
      if (msg_accept) begin
        msg_valid <= 1'b0;
      end
    end else if (next_found) begin
      msg_valid <= 1'b1;
      msg_input <= next_sel;
      msg_dest_logical <= sel_cfg[`IIR_BIT_DMODE];
      msg_dest <= dest_of(sel_cfg[`IIR_BIT_DMODE], sel_dest);
      msg_delivery <= sel_cfg[`IIR_DLV_HI:`IIR_DLV_LO];
      msg_level <= sel_cfg[`IIR_BIT_TRIG];
      msg_vector <= sel_cfg[`IIR_VEC_HI:`IIR_VEC_LO];
    end
  end

  // read data chosen a cycle ahead so that mem_rdata is a plain flip-flop
  always @* begin
    next_rvalid = mem_rd && (sel_index || sel_data);
    next_rdata = 32'h00000000;
    if (mem_rd && sel_index) begin
      next_rdata = {24'h000000, index};
    end else if (mem_rd && sel_data) begin
      case (index)
        `IIR_IDX_IDENTITY: begin
          next_rdata = {4'h0, unit_id, 24'h000000};
        end
        `IIR_IDX_VERSION: begin
          next_rdata = VERSION_VALUE;
        end
        `IIR_IDX_ARB: begin
          next_rdata = {4'h0, arb_id, 24'h000000};
        end
        default: begin
          if (cur_is_ent && cur_ent < N_IN) begin
            if (index[0]) begin
              next_rdata = {ent_dest[cur_ent], 24'h000000};
            end else begin
              next_rdata = low_word(ent_low[cur_ent], request_received_flag[cur_ent], pend[cur_ent]);
            end
          end else begin
            next_rdata = 32'h00000000;
          end
        end
      endcase
    end
  end

  // read answer registered one cycle after the strobe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_rdata <= 32'h00000000;
      mem_rvalid <= 1'b0;
    end else begin
      mem_rdata <= next_rdata;
      mem_rvalid <= next_rvalid;
    end
  end

endmodule

// ---- iir_props.sv ----
// port checker for the indexed interrupt redirector
// assumes one clock domain and the constants of iir_defines.vh
`include "iir_defines.vh"
module iir_props_chk #(
  parameter N_IN = 24
) (
  input wire clk,
  input wire reset_n,
  input wire [31:0] mem_addr,
  input wire mem_wr,
  input wire mem_rd,
  input wire [3:0] mem_be,
  input wire [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_rvalid,
  input wire msg_valid,
  input wire [7:0] msg_dest,
  input wire msg_dest_logical,
  input wire [7:0] msg_vector,
  input wire [4:0] msg_input,
  input wire msg_accept
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  reg [7:0] idx_q;
  wire dec = mem_addr == `IIR_ADDR_INDEX || mem_addr == `IIR_ADDR_DATA;
  wire data_rd = mem_rd && mem_addr == `IIR_ADDR_DATA;
  // shadow of the index register
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      idx_q <= 8'h00;
    else if (mem_wr && mem_be[0] && mem_addr == `IIR_ADDR_INDEX)
      idx_q <= mem_wdata[7:0];
  end
  sequence s_rd_unmapped;
    data_rd && (idx_q >= 8'h40 || (idx_q > 8'h02 && idx_q < 8'h10));
  endsequence
  sequence s_rd_ident;
    data_rd && idx_q == `IIR_IDX_IDENTITY;
  endsequence
  sequence s_msg_taken;
    msg_valid && msg_accept;
  endsequence
  AST_RD_ANSWER: assert property (mem_rd && dec |=> mem_rvalid) else $error("read not answered");
  AST_RD_NONE: assert property (!(mem_rd && dec) |=> !mem_rvalid) else $error("stray read answer");
  AST_RDATA_IDLE: assert property (!mem_rvalid |-> mem_rdata == 32'h0) else $error("idle data nonzero");
  AST_UNMAPPED_ZERO: assert property (s_rd_unmapped |=> mem_rdata == 32'h0) else $error("unmapped nonzero");
  AST_IDENT_RSVD: assert property (s_rd_ident |=> mem_rdata[31:28] == 4'h0 && mem_rdata[23:0] == 24'h0)
    else $error("identity reserved bits set");
  AST_MSG_HOLD: assert property (msg_valid && !msg_accept |=> msg_valid && $stable(msg_vector) && $stable(msg_input))
    else $error("message changed before accept");
  AST_MSG_DROP: assert property (s_msg_taken |=> !msg_valid) else $error("message held after accept");
  AST_DEST_PHYS: assert property (msg_valid && !msg_dest_logical |-> msg_dest[7:4] == 4'h0)
    else $error("physical destination too wide");
  AST_INPUT_RANGE: assert property (msg_valid |-> msg_input < N_IN) else $error("input number out of range");
endmodule
bind iir_redirector iir_props_chk #(.N_IN(N_IN)) i_iir_props_chk (.*);

// ---- iir_cpu_model.sv ----
// processor side model: accepts interrupt messages promptly or slowly
// assumes the redirector holds msg_valid until accepted
module iir_cpu_model (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // message link
  input wire msg_valid,
  input wire slow,
  output reg msg_accept
);
  reg [2:0] wait_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      msg_accept <= 1'b0;
      wait_q <= 3'h0;
    end else if (msg_valid && !msg_accept) begin
      wait_q <= wait_q + 3'h1;
      msg_accept <= !slow || wait_q == 3'h7;
    end else begin
      msg_accept <= 1'b0;
      wait_q <= 3'h0;
    end
  end
endmodule

// ---- iir_redirector_tb_top.sv ----
// self-checking bench for the indexed interrupt redirector
// assumes the design, processor model and checker bind are compiled first
`include "iir_defines.vh"
module iir_redirector_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [31:0] VER = 32'h00a50003; // arbitrary value
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg [31:0] mem_addr = 32'h0;
  reg mem_wr = 1'b0;
  reg mem_rd = 1'b0;
  reg [3:0] mem_be = 4'h0;
  reg [31:0] mem_wdata = 32'h0;
  reg [23:0] irq_in = 24'h0;
  reg eoi_valid = 1'b0;
  reg [7:0] eoi_vector = 8'h0;
  reg slow = 1'b0;
  wire [31:0] mem_rdata;
  wire mem_rvalid, msg_valid, msg_dest_logical, msg_level, msg_accept;
  wire [7:0] msg_dest, msg_vector;
  wire [2:0] msg_delivery;
  wire [4:0] msg_input;
  int err_total = 0;
  int check_count = 0;
  always #50 clk = ~clk;
  iir_redirector #(.VERSION_VALUE(VER)) i_iir_redirector (
    .clk(clk), .reset_n(reset_n), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .irq_in(irq_in), .msg_valid(msg_valid), .msg_dest(msg_dest), .msg_dest_logical(msg_dest_logical),
    .msg_delivery(msg_delivery), .msg_level(msg_level), .msg_vector(msg_vector), .msg_input(msg_input),
    .msg_accept(msg_accept), .eoi_valid(eoi_valid), .eoi_vector(eoi_vector)
  );
  iir_cpu_model i_iir_cpu_model (
    .clk(clk), .reset_n(reset_n), .msg_valid(msg_valid), .slow(slow), .msg_accept(msg_accept)
  );
  task conclude;
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    mem_wr <= wr;
    mem_rd <= !wr;
    mem_addr <= a;
    mem_wdata <= d;
    mem_be <= be;
    @(posedge clk);
    mem_wr <= 1'b0;
    mem_rd <= 1'b0;
  endtask
  task wrx(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, `IIR_ADDR_INDEX, {24'h0, idx}, 4'h1);
    bus(1'b1, `IIR_ADDR_DATA, d, be);
  endtask
  task rd(input logic [7:0] idx, output logic [31:0] q);
    int i;
    bus(1'b1, `IIR_ADDR_INDEX, {24'h0, idx}, 4'h1);
    bus(1'b0, `IIR_ADDR_DATA, 32'h0, 4'h0);
    for (i = 0; i < 4 && mem_rvalid !== 1'b1; i++) @(posedge clk);
    if (mem_rvalid !== 1'b1) begin
      err_total++;
      conclude;
    end else begin
      q = mem_rdata;
    end
  endtask
  task wmv(input logic lvl);
    int i;
    for (i = 0; i < 40 && msg_valid !== lvl; i++) @(posedge clk);
    if (msg_valid !== lvl) begin
      err_total++;
      conclude;
    end
  endtask
  task eoi(input logic [7:0] v);
    @(posedge clk);
    eoi_valid <= 1'b1;
    eoi_vector <= v;
    @(posedge clk);
    eoi_valid <= 1'b0;
  endtask
  task t_reset;
    logic [31:0] q;
    int n;
    rd(8'h00, q); chk(q, 32'h0);
    rd(8'h01, q); chk(q, VER);
    rd(8'h02, q); chk(q, 32'h0);
    rd(8'h40, q); chk(q, 32'h0);
    for (n = 0; n < 24; n++) begin
      rd(8'(16 + 2 * n), q); chk(q, 32'h00010000);
      rd(8'(17 + 2 * n), q); chk(q, 32'h0);
    end
  endtask
  task t_regs;
    logic [31:0] q;
    wrx(8'h00, 32'hffffffff, 4'hf);
    rd(8'h00, q); chk(q, 32'h0f000000);
    wrx(8'h02, 32'h0, 4'hf);
    rd(8'h02, q); chk(q, 32'h0f000000);
    wrx(8'h10, 32'hffffffff, 4'h3);
    rd(8'h10, q); chk(q, 32'h00010000);
    wrx(8'h10, 32'hffffffff, 4'hf);
    rd(8'h10, q); chk(q, 32'h0001afff);
    wrx(8'h11, 32'hffffffff, 4'hf);
    rd(8'h11, q); chk(q, 32'hff000000);
    bus(1'b0, `IIR_ADDR_INDEX, 32'h0, 4'h0);
    @(posedge clk); chk(mem_rdata, 32'h00000011);
    bus(1'b0, 32'hfec00020, 32'h0, 4'h0);
    @(posedge clk); chk({31'h0, mem_rvalid}, 32'h0);
  endtask
  task t_edge;
    logic [31:0] q, lo;
    logic [3:0] m;
    for (m = 0; m < 8; m++) begin
      lo = {20'h0, m[0], m[2:0], 4'h3, m};
      wrx(8'h17, {m[0] ? 8'h5a : 8'ha5, 24'h0}, 4'hf);
      wrx(8'h16, lo, 4'hf);
      slow <= 1'b1;
      irq_in[3] <= 1'b1;
      wmv(1'b1);
      chk({msg_input, msg_level, msg_delivery, msg_vector}, {15'h0, 5'd3, 1'b0, m[2:0], 4'h3, m});
      chk({msg_dest_logical, msg_dest}, {m[0], m[0] ? 8'h5a : 8'h05});
      rd(8'h16, q); chk(q, lo | 32'h1000);
      irq_in[3] <= 1'b0;
      wmv(1'b0);
      rd(8'h16, q); chk(q, lo);
    end
    slow <= 1'b0;
  endtask
  task t_level;
    logic [31:0] q;
    irq_in[5] <= 1'b1;
    wrx(8'h1b, 32'h01000000, 4'hf);
    wrx(8'h1a, 32'h0000a041, 4'hf);
    irq_in[5] <= 1'b0;
    wmv(1'b1);
    chk({msg_level, msg_vector}, {23'h0, 9'h141});
    wmv(1'b0);
    rd(8'h1a, q); chk(q, 32'h0000e041);
    repeat (8) begin
      @(posedge clk); chk({31'h0, msg_valid}, 32'h0);
    end
    eoi(8'h41);
    wmv(1'b1);
    wmv(1'b0);
    irq_in[5] <= 1'b1;
    eoi(8'h41);
    rd(8'h1a, q); chk(q, 32'h0000a041);
  endtask
  task t_mask;
    wrx(8'h1e, 32'h00010050, 4'hf);
    irq_in[7] <= 1'b1;
    repeat (10) begin
      @(posedge clk); chk({31'h0, msg_valid}, 32'h0);
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_regs;
    t_edge;
    t_level;
    t_mask;
    conclude;
  end
endmodule
